/* File: hw/link_final_train.sv */
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module link_final_train #(
	parameter int LANES = 8,
	parameter int PAT_E = link_train_pkg::PAT_EDGES,
	parameter int T3_CYC = link_train_pkg::T3_CYCLES,
	parameter int SKEW_CYC = link_train_pkg::SKEW_CYCLES
) (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// asynchronous pins and lane levels
	input  wire logic                link_clk,
	input  wire logic                stop_request_n,
	input  wire logic                link_reset_n,
	input  wire logic                lanes_deskewed,
	input  wire logic [LANES-1:0]    lane_marker,
	// same-clock training and packet events
	input  wire logic [LANES-1:0]    lane_active,
	input  wire logic                t3_enter,
	input  wire logic                rx_pkt_good,
	input  wire logic                rx_error,
	input  wire logic                rx_idle,
	input  wire logic                rx_idle_disc,
	input  wire logic [7:0]          rx_idle_seq,
	input  wire logic                flood_rx,
	// transmit control
	output logic                     tx_send_tp3,
	output logic                     tx_send_marker,
	output logic                     scram_load_ones,
	output logic                     scram_en,
	output logic                     disp_neg_start,
	output logic                     send_idle,
	output logic                     replay_start,
	output logic      [7:0]          replay_seq,
	// receive control
	output logic                     descram_init,
	output logic                     rx_check_en,
	output logic                     fifo_rd_start,
	// state
	output logic      [2:0]          link_state,
	output logic      [1:0]          t0_sel,
	output logic                     flood_all
);

	// refuse parameter values the logic cannot serve
	if (LANES < 1 || LANES > 24 || PAT_E < 1 || T3_CYC < 2 ||
	    SKEW_CYC < 1) begin : g_bad_param
		$error("link_final_train: unsupported parameters");
	end

	// ****************************************
	// reset and synchronisers
	// ****************************************
	logic [1:0] rst_sh_r;
	logic       rst_s_b;

	// release reset through two flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) rst_sh_r <= 2'h0;
		else        rst_sh_r <= {rst_sh_r[0], 1'b1};
	end
	assign rst_s_b = rst_sh_r[1];

	logic [LANES+3:0] sync_q;
	logic             lclk_s, stop_s_n, lrst_s_n, deskew_s;
	logic             stop_s, lrst_s;
	logic [LANES-1:0] mark_s;

	sync_two_flop #(.W(LANES+4)) u_sync (
		.clk      (sys_clk),
		.rst_b    (rst_s_b),
		.async_in ({link_clk, ~stop_request_n, ~link_reset_n,
		            lanes_deskewed, lane_marker}),
		.sync_out (sync_q)
	);
	assign {lclk_s, stop_s, lrst_s, deskew_s, mark_s} = sync_q;
	// active-low pins cross inverted, so a flop reset reads as released
	assign stop_s_n = !stop_s;
	assign lrst_s_n = !lrst_s;

	// ****************************************
	// registers
	// ****************************************
	link_train_pkg::link_state_t state_r, state_nxt;
	link_train_pkg::tx_phase_t   tx_ph_r;
	logic [2:0]  ctrl_r;
	logic [7:0]  perm_r, total_r, att_r, tally_r, att_n, tally_n;
	logic        init_r, fail_r, err0_r;
	logic        rx_oper_r, mark_seen_r, stop_pend_r, rx_retry_r;
	logic        xchg_r, prev_disc_r, lclk_d_r;
	logic [31:0] t3_cnt_r;
	logic [15:0] skew_cnt_r;
	logic [15:0] pat_cnt_r;
	logic [3:0]  tp3_cnt_r;
	logic        wr_en, rd_en, mapped, ledge, pat_end;
	logic        mark_any, mark_all, expire, skew_fail, fall;
	logic        over_perm, over_all, tx_done, in_t3, in_op, wr_stat;

	assign in_t3   = (state_r == link_train_pkg::ST_T3);
	assign in_op   = (state_r == link_train_pkg::ST_OPER);
	assign tx_done = (tx_ph_r == link_train_pkg::TX_DONE);

	// apb decode, zero wait states
	assign mapped  = (paddr == link_train_pkg::OFS_CTRL) ||
	                 (paddr == link_train_pkg::OFS_LIMIT) ||
	                 (paddr == link_train_pkg::OFS_STATUS) ||
	                 (paddr == link_train_pkg::OFS_COUNT);
	assign wr_en   = psel && penable && pwrite && mapped;
	assign rd_en   = psel && !penable && !pwrite;
	assign wr_stat = wr_en && (paddr == link_train_pkg::OFS_STATUS);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// read data captured in the setup cycle
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) prdata <= 32'h0;
		else if (rd_en) begin
			case (paddr)
			link_train_pkg::OFS_CTRL:   prdata <= {29'h0, ctrl_r};
			link_train_pkg::OFS_LIMIT:  prdata <= {16'h0, total_r, perm_r};
			link_train_pkg::OFS_STATUS: prdata <= {24'h0, rx_oper_r,
				tx_done, err0_r, fail_r, init_r, state_r};
			link_train_pkg::OFS_COUNT:  prdata <= {16'h0, tally_r, att_r};
			default:                    prdata <= 32'h0;
			endcase
		end
	end

	// control and limit registers, flood bit self-clears
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			ctrl_r  <= link_train_pkg::CTRL_RST;
			perm_r  <= link_train_pkg::PERM_RST;
			total_r <= link_train_pkg::TOTAL_RST;
		end else begin
			ctrl_r[link_train_pkg::CTRL_FLOOD] <= 1'b0;
			if (wr_en && paddr == link_train_pkg::OFS_CTRL)
				ctrl_r <= pwdata[2:0];
			if (wr_en && paddr == link_train_pkg::OFS_LIMIT) begin
				perm_r  <= pwdata[7:0];
				total_r <= pwdata[15:8];
			end
		end
	end

	// ****************************************
	// transmit side of phase three
	// ****************************************
	assign ledge   = lclk_s && !lclk_d_r;
	assign pat_end = ledge && (pat_cnt_r == 16'(PAT_E - 1));

	// pattern framing from link clock edges
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			lclk_d_r  <= 1'b0;
			pat_cnt_r <= 16'h0;
			tp3_cnt_r <= 4'h0;
			tx_ph_r   <= link_train_pkg::TX_TP3;
		end else begin
			lclk_d_r <= lclk_s;
			if (!in_t3) begin
				pat_cnt_r <= 16'h0;
				tp3_cnt_r <= 4'h0;
				if (state_r != link_train_pkg::ST_OPER)
					tx_ph_r <= link_train_pkg::TX_TP3;
			end else if (ledge) begin
				pat_cnt_r <= pat_end ? 16'h0 : pat_cnt_r + 16'h1;
				if (pat_end) begin
					case (tx_ph_r)
					link_train_pkg::TX_TP3: begin
						tp3_cnt_r <= tp3_cnt_r + 4'h1;
						if (tp3_cnt_r == link_train_pkg::T3_PATTERNS - 4'h1)
							tx_ph_r <= link_train_pkg::TX_MARK;
					end
					link_train_pkg::TX_MARK: tx_ph_r <= link_train_pkg::TX_DONE;
					default: tx_ph_r <= tx_ph_r;
					endcase
				end
			end
		end
	end
	assign tx_send_tp3    = in_t3 && tx_ph_r == link_train_pkg::TX_TP3;
	assign tx_send_marker = in_t3 && tx_ph_r == link_train_pkg::TX_MARK;

	// scrambler seed and enable right after the marker
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			scram_load_ones <= 1'b0;
			disp_neg_start  <= 1'b0;
			scram_en        <= 1'b0;
		end else begin
			scram_load_ones <= tx_send_marker && pat_end;
			disp_neg_start  <= tx_send_marker && pat_end &&
			                   ctrl_r[link_train_pkg::CTRL_AC];
			if (tx_send_marker && pat_end)
				scram_en <= 1'b1;
			else if (state_nxt == link_train_pkg::ST_FLOOD)
				scram_en <= 1'b1;
			else if (state_nxt != link_train_pkg::ST_OPER &&
			         state_nxt != link_train_pkg::ST_T3)
				scram_en <= 1'b0;
		end
	end

	// ****************************************
	// receive side of phase three
	// ****************************************
	assign mark_any  = |(mark_s & lane_active);
	assign mark_all  = &(mark_s | ~lane_active);
	assign skew_fail = mark_seen_r && !mark_all &&
	                   skew_cnt_r >= 16'(SKEW_CYC);
	assign expire    = in_t3 && t3_cnt_r == 32'(T3_CYC - 1);

	// marker tracking, deskew and skew window
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			mark_seen_r  <= 1'b0;
			descram_init <= 1'b0;
			rx_oper_r    <= 1'b0;
			skew_cnt_r   <= 16'h0;
		end else if (!in_t3) begin
			descram_init <= 1'b0;
			skew_cnt_r   <= 16'h0;
			if (!in_op) begin
				mark_seen_r <= 1'b0;
				rx_oper_r   <= 1'b0;
			end
		end else begin
			mark_seen_r  <= mark_seen_r || mark_any;
			descram_init <= mark_any && !mark_seen_r;
			if (mark_seen_r && !mark_all)
				skew_cnt_r <= skew_cnt_r + 16'h1;
			if (deskew_s && mark_any && (mark_all ||
			    !ctrl_r[link_train_pkg::CTRL_ALL]))
				rx_oper_r <= 1'b1;
		end
	end
	assign rx_check_en   = mark_seen_r;
	assign fifo_rd_start = mark_seen_r;

	// phase-three timer from each entry
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) t3_cnt_r <= 32'h0;
		else if (!in_t3) t3_cnt_r <= 32'h0;
		else if (!expire) t3_cnt_r <= t3_cnt_r + 32'h1;
	end

	// ****************************************
	// retry accounting
	// ****************************************
	assign fall      = in_t3 && (skew_fail ||
	                   (expire && !(rx_oper_r && tx_done)));
	assign att_n     = (att_r == 8'hff) ? att_r : att_r + 8'h1;
	assign tally_n   = (tally_r == 8'hff) ? tally_r : tally_r + 8'h1;
	assign over_perm = att_n > perm_r;
	assign over_all  = tally_n > total_r;

	// counters and sticky flags, set wins over clear
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			att_r   <= 8'h0;
			tally_r <= 8'h0;
			init_r  <= 1'b0;
			fail_r  <= 1'b0;
			err0_r  <= 1'b0;
			t0_sel  <= link_train_pkg::T0_KEEP;
		end else begin
			if (fall) begin
				att_r   <= att_n;
				tally_r <= tally_n;
				if (skew_fail)
					t0_sel <= link_train_pkg::T0_0US;
				else if (over_perm)
					t0_sel <= link_train_pkg::T0_200US;
				else
					t0_sel <= link_train_pkg::T0_KEEP;
			end else if (in_op && rx_pkt_good) begin
				tally_r <= 8'h0;
			end
			if (wr_stat && pwdata[link_train_pkg::STAT_INIT]) init_r <= 1'b0;
			if (wr_stat && pwdata[link_train_pkg::STAT_FAIL]) fail_r <= 1'b0;
			if (wr_stat && pwdata[link_train_pkg::STAT_ERR0]) err0_r <= 1'b0;
			if (in_op && rx_pkt_good) init_r <= 1'b1;
			if (fall && over_perm && over_all) begin
				fail_r <= 1'b1;
				err0_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// operational entry and link state
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			stop_pend_r <= 1'b0;
			rx_retry_r  <= 1'b0;
		end else if (!in_t3) begin
			stop_pend_r <= 1'b0;
			rx_retry_r  <= 1'b0;
		end else begin
			if (!stop_s_n) stop_pend_r <= 1'b1;
			if (rx_oper_r && (rx_error || (rx_idle && rx_idle_disc)))
				rx_retry_r <= 1'b1;
		end
	end

	// next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
		link_train_pkg::ST_IDLE:
			if (t3_enter) state_nxt = link_train_pkg::ST_T3;
		link_train_pkg::ST_T3:
			if (fall)
				state_nxt = (over_perm && over_all) ?
				            link_train_pkg::ST_FLOOD :
				            link_train_pkg::ST_BACK;
			else if (tx_done && rx_retry_r)
				state_nxt = link_train_pkg::ST_RETRY;
			else if (tx_done && rx_oper_r)
				state_nxt = link_train_pkg::ST_OPER;
			else if (tx_done && stop_pend_r)
				state_nxt = link_train_pkg::ST_STOP;
		link_train_pkg::ST_OPER:
			if (flood_rx || ctrl_r[link_train_pkg::CTRL_FLOOD])
				state_nxt = link_train_pkg::ST_FLOOD;
			else if (!stop_s_n || stop_pend_r)
				state_nxt = link_train_pkg::ST_STOP;
			else if (rx_error)
				state_nxt = link_train_pkg::ST_RETRY;
			else if (rx_idle && rx_idle_disc && prev_disc_r)
				state_nxt = link_train_pkg::ST_STOP;
			else if (rx_idle && !rx_idle_disc && prev_disc_r)
				state_nxt = link_train_pkg::ST_RETRY;
		link_train_pkg::ST_FLOOD: state_nxt = state_r;
		link_train_pkg::ST_WARM:
			if (lrst_s_n) state_nxt = link_train_pkg::ST_IDLE;
		default: state_nxt = link_train_pkg::ST_IDLE;
		endcase
		if (!lrst_s_n) state_nxt = link_train_pkg::ST_WARM;
	end

	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) state_r <= link_train_pkg::ST_IDLE;
		else          state_r <= state_nxt;
	end
	assign link_state = state_r;
	assign flood_all  = (state_r == link_train_pkg::ST_FLOOD);

	// idle exchange and replay start
	always_ff @(posedge sys_clk or negedge rst_s_b) begin
		if (!rst_s_b) begin
			xchg_r       <= 1'b0;
			prev_disc_r  <= 1'b0;
			replay_start <= 1'b0;
			replay_seq   <= 8'h0;
		end else begin
			replay_start <= 1'b0;
			if (!in_op) begin
				xchg_r      <= 1'b0;
				prev_disc_r <= 1'b0;
			end else if (rx_idle) begin
				prev_disc_r <= rx_idle_disc;
				if (!rx_idle_disc && !xchg_r) begin
					xchg_r       <= 1'b1;
					replay_start <= 1'b1;
					replay_seq   <= rx_idle_seq + 8'h1;
				end
			end
		end
	end
	assign send_idle = in_op && !xchg_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_s_b);

	marker_after_eight_a: assert property (
		$rose(tx_send_marker) |-> $past(tp3_cnt_r) ==
			link_train_pkg::T3_PATTERNS - 4'h1)
		else $error("marker not after eight patterns");
	descram_start_a: assert property (
		in_t3 && mark_any && !mark_seen_r |=> descram_init && rx_check_en)
		else $error("descrambler not started on marker");
	oper_entry_a: assert property (
		in_t3 ##1 state_r == link_train_pkg::ST_OPER |->
			$past(rx_oper_r) && $past(tx_done))
		else $error("operational entered too early");
	retry_count_a: assert property (
		fall |=> att_r == $past(att_n) && tally_r == $past(tally_n))
		else $error("retry counters not bumped");
	fail_flood_a: assert property (
		fall && over_perm && over_all && lrst_s_n |=>
			state_r == link_train_pkg::ST_FLOOD && fail_r && err0_r &&
			scram_en)
		else $error("failure escalation wrong");
	skew_zero_a: assert property (
		in_t3 && skew_fail |=> t0_sel == link_train_pkg::T0_0US)
		else $error("skew fallback timer wrong");
	timer_start_a: assert property (
		$rose(in_t3) |-> t3_cnt_r == 32'h0 ##1 t3_cnt_r == 32'h1)
		else $error("phase three timer not started");
	error_retry_a: assert property (
		in_op && rx_error && lrst_s_n && stop_s_n && !stop_pend_r &&
		!flood_rx && !ctrl_r[link_train_pkg::CTRL_FLOOD] |=>
			state_r == link_train_pkg::ST_RETRY)
		else $error("error did not start replay disconnect");
	two_disc_a: assert property (
		in_op && rx_idle && rx_idle_disc && prev_disc_r && lrst_s_n |=>
			state_r inside {link_train_pkg::ST_STOP,
			                link_train_pkg::ST_FLOOD,
			                link_train_pkg::ST_RETRY})
		else $error("two disconnect idles ignored");
	init_done_a: assert property (
		in_op && rx_pkt_good |=> init_r && tally_r == 8'h0)
		else $error("good packet did not finish init");

	oper_reached_c: cover property (in_t3 ##1 in_op);
	replay_c:       cover property (replay_start);
	flood_c:        cover property (fall && over_perm && over_all);
	back_c:         cover property (fall && !over_perm);

endmodule // link_final_train
`default_nettype wire

/* File: hw/link_train_pkg.sv */
`default_nettype none
package link_train_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LIMIT  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_COUNT  = 8'h0c;

	// control bits
	localparam int CTRL_AC    = 0;
	localparam int CTRL_ALL   = 1;
	localparam int CTRL_FLOOD = 2;

	// status bits
	localparam int STAT_INIT  = 3;
	localparam int STAT_FAIL  = 4;
	localparam int STAT_ERR0  = 5;
	localparam int STAT_TXOP  = 6;
	localparam int STAT_RXOP  = 7;

	// reset values
	localparam logic [2:0]  CTRL_RST  = 3'h0;
	localparam logic [7:0]  PERM_RST  = 8'h03;
	localparam logic [7:0]  TOTAL_RST = 8'h0f;

	// ****************************************
	// counts
	// ****************************************
	localparam logic [3:0] T3_PATTERNS = 4'h8;
	localparam int         PAT_EDGES   = 4;
	localparam int         T3_CYCLES   = 8192;
	localparam int         SKEW_CYCLES = 16;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_T3    = 3'h1,
		ST_OPER  = 3'h3,
		ST_RETRY = 3'h2,
		ST_STOP  = 3'h6,
		ST_FLOOD = 3'h7,
		ST_BACK  = 3'h5,
		ST_WARM  = 3'h4
	} link_state_t;

	// training0 timer selection on fallback
	typedef enum logic [1:0] {
		T0_KEEP = 2'h0,
		T0_200US = 2'h1,
		T0_0US  = 2'h2
	} t0_sel_t;

	typedef enum logic [1:0] {
		TX_TP3  = 2'h0,
		TX_MARK = 2'h1,
		TX_DONE = 2'h3
	} tx_phase_t;

endpackage
`default_nettype wire

/* File: hw/sync_two_flop.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// two flops, first one read only by the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // sync_two_flop
`default_nettype wire

/* File: testbench/peer_endpoint.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// peer endpoint: link clock, lane markers, idle replies
// ********
module peer_endpoint #(
	parameter int LANES = 4
) (
	// clock
	input	wire logic		sys_clk,
	// bench knobs
	input	wire logic		arm,
	input	wire logic [3:0]	gap,
	input	wire logic [1:0]	disc,
	input	wire logic		two,
	input	wire logic [7:0]	seq,
	// device state
	input	wire logic		in_t3,
	input	wire logic		tx_on,
	input	wire logic		send_idle,
	// toward device
	output	logic			link_clk,
	output	logic [LANES-1:0]	lane_marker,
	output	logic			lanes_deskewed,
	output	logic			rx_idle,
	output	logic			rx_idle_disc,
	output	logic [7:0]		rx_idle_seq
);
	int		t = 0;
	logic [2:0]	c = 3'h0;

	// clock only toggles while a pattern frame is on the wire
	initial link_clk = 1'b0;
	always #24 link_clk = tx_on ? ~link_clk : 1'b0;

	// peer ends its patterns with one marker per lane, skewed by gap
	always_ff @(posedge sys_clk) t <= (in_t3 && arm) ? t + 1 : 0;
	always_comb begin
		for (int i = 0; i < LANES; i++)
			lane_marker[i] = in_t3 && arm && t >= 60 + i * gap;
	end
	assign lanes_deskewed = &lane_marker;

	// idle replies a few cycles after ours begin
	always_ff @(posedge sys_clk) begin
		if (in_t3)
			c <= 3'h0;
		else if (c != 3'h0 && c != 3'h7)
			c <= c + 3'h1;
		else if (c == 3'h0 && send_idle)
			c <= 3'h1;
	end
	assign rx_idle = c == 3'h3 || (two && c == 3'h4);
	assign rx_idle_disc = c == 3'h3 ? disc[0] : disc[1];
	// sequence field is junk outside the idle pulse
	assign rx_idle_seq = rx_idle ? seq : ~seq;
endmodule // peer_endpoint
`default_nettype wire

/* File: testbench/link_final_training_and_operational_fsm_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module link_final_training_and_operational_fsm_bench;
	localparam int LN = 4;
	localparam int PE = 2;
	// ********
	// signals
	// ********
	logic		sys_clk = 1'b0;
	logic		rst_b = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0;
	logic		stop_request_n = 1'b1;
	logic		link_reset_n = 1'b1;
	logic		t3_enter = 1'b0;
	logic		rx_pkt_good = 1'b0;
	logic		rx_error = 1'b0;
	logic		flood_rx = 1'b0;
	logic		arm = 1'b0;
	logic		two = 1'b0;
	logic [3:0]	gap = 4'h0;
	logic [1:0]	disc = 2'h0;
	logic [7:0]	seq = 8'h00;
	logic [31:0]	prdata, rd;
	logic [LN-1:0]	lane_marker;
	logic [7:0]	rx_idle_seq, replay_seq, rep_q;
	logic [2:0]	link_state;
	logic [1:0]	t0_sel;
	logic		pready, pslverr, err, link_clk, lanes_deskewed;
	logic		rx_idle, rx_idle_disc, tx_send_tp3, tx_send_marker;
	logic		scram_load_ones, scram_en, disp_neg_start, send_idle;
	logic		replay_start, descram_init, rx_check_en, fifo_rd_start;
	logic		flood_all, in_t3, tx_on;
	int		n_mismatch = 0;
	int		num_checks = 0;
	int		n_tp3, n_mk, n_seed, n_neg, n_dsi;

	// clock and partner hints
	always #2 sys_clk = ~sys_clk;
	assign in_t3 = link_state == link_train_pkg::ST_T3;
	assign tx_on = tx_send_tp3 | tx_send_marker;

	link_final_train #(.LANES(LN), .PAT_E(PE), .T3_CYC(400), .SKEW_CYC(4))
	link_final_train_i (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link_clk, .stop_request_n,
		.link_reset_n, .lanes_deskewed, .lane_marker,
		.lane_active({LN{1'b1}}), .t3_enter, .rx_pkt_good, .rx_error,
		.rx_idle, .rx_idle_disc, .rx_idle_seq, .flood_rx, .tx_send_tp3,
		.tx_send_marker, .scram_load_ones, .scram_en, .disp_neg_start,
		.send_idle, .replay_start, .replay_seq, .descram_init,
		.rx_check_en, .fifo_rd_start, .link_state, .t0_sel, .flood_all);
	peer_endpoint #(.LANES(LN)) peer_endpoint_i (.sys_clk, .arm, .gap,
		.disc, .two, .seq, .in_t3, .tx_on, .send_idle, .link_clk,
		.lane_marker, .lanes_deskewed, .rx_idle, .rx_idle_disc,
		.rx_idle_seq);

	// count pattern edges and seed pulses, latch the replay sequence
	always @(posedge link_clk) begin
		n_tp3 += tx_send_tp3;
		n_mk += tx_send_marker;
	end
	always @(posedge sys_clk) begin
		n_seed += scram_load_ones;
		n_neg += disp_neg_start && scram_load_ones;
		n_dsi += descram_init;
		if (replay_start === 1'b1)
			rep_q = replay_seq;
	end

	// ********
	// tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// bit 3 phase entry, 2 good packet, 1 error, 0 flood
	task automatic pulse(input int w);
		@(posedge sys_clk);
		{t3_enter, rx_pkt_good, rx_error, flood_rx} <= 4'(1 << w);
		@(posedge sys_clk);
		{t3_enter, rx_pkt_good, rx_error, flood_rx} <= 4'h0;
	endtask

	task automatic wait_st(input logic [2:0] s, input string m);
		#1;
		for (int n = 0; n < 1000 && link_state !== s; n++) begin
			@(posedge sys_clk);
			#1;
		end
		chk(link_state, s, m);
	endtask

	task automatic train(input logic a, input logic [3:0] g,
		input logic [1:0] d, input logic t);
		@(posedge sys_clk);
		arm <= a;
		gap <= g;
		disc <= d;
		two <= t;
		seq <= 8'($urandom);
		n_tp3 = 0;
		n_mk = 0;
		n_seed = 0;
		n_neg = 0;
		n_dsi = 0;
		rep_q = 8'hxx;
		pulse(3);
	endtask

	task automatic warm;
		@(posedge sys_clk);
		link_reset_n <= 1'b0;
		wait_st(link_train_pkg::ST_WARM, "warm");
		@(posedge sys_clk);
		link_reset_n <= 1'b1;
		wait_st(link_train_pkg::ST_IDLE, "idle");
	endtask

	// train to operational, then leave it by exit kind k
	task automatic oper(input int k);
		train(1'b1, 4'(k % 2), k == 1 ? 2'h3 : 2'(k == 2), 1'(k == 1 || k == 2));
		wait_st(link_train_pkg::ST_OPER, "oper");
		chk(n_tp3, 8 * PE, "tp3 edges");
		chk(n_mk, PE, "marker edges");
		chk({n_seed[3:0], n_neg[3:0]}, 8'h11, "seed");
		chk(n_dsi, 32'h1, "descram init");
		chk({rx_check_en, fifo_rd_start, scram_en, send_idle}, 4'hf, "on");
		if (k == 1)
			wait_st(link_train_pkg::ST_STOP, "disc disc");
		else if (k == 2)
			wait_st(link_train_pkg::ST_RETRY, "disc idle");
		else begin
			// partner answers within four cycles, replay one later
			repeat (8) @(posedge sys_clk);
			chk(rep_q, 8'(seq + 8'h1), "replay");
			if (k == 0) begin
				pulse(2);
				apb(1'b0, link_train_pkg::OFS_STATUS, 32'h0);
				chk(rd & 32'h8, 32'h8, "init");
				apb(1'b0, link_train_pkg::OFS_COUNT, 32'h0);
				chk(rd & 32'hff00, 32'h0, "tally");
				pulse(1);
				wait_st(link_train_pkg::ST_RETRY, "err");
			end else if (k == 3) begin
				@(posedge sys_clk);
				stop_request_n <= 1'b0;
				wait_st(link_train_pkg::ST_STOP, "stop");
				@(posedge sys_clk);
				stop_request_n <= 1'b1;
			end else begin
				if (k == 4)
					apb(1'b1, link_train_pkg::OFS_CTRL, 32'h7);
				else
					pulse(0);
				wait_st(link_train_pkg::ST_FLOOD, "flood");
				warm;
			end
		end
		wait_st(link_train_pkg::ST_IDLE, "back idle");
		$display("test oper %0d done", k);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ********
	// main sequence
	// ********
	initial begin
		void'($urandom(18));
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		apb(1'b0, link_train_pkg::OFS_LIMIT, 32'h0);
		chk(rd, {16'h0, link_train_pkg::TOTAL_RST, link_train_pkg::PERM_RST}, "lim");
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(err), 32'h1, "unmapped");
		// no marker: timer expiry keeps training0 timer
		train(1'b0, 4'h0, 2'h0, 1'b0);
		wait_st(link_train_pkg::ST_BACK, "expiry");
		chk(t0_sel, link_train_pkg::T0_KEEP, "keep");
		apb(1'b0, link_train_pkg::OFS_COUNT, 32'h0);
		chk(rd & 32'hffff, 32'h0101, "counts");
		$display("test timeout done");
		// wide marker skew
		train(1'b1, 4'h3, 2'h0, 1'b0);
		wait_st(link_train_pkg::ST_BACK, "skew");
		chk(t0_sel, link_train_pkg::T0_0US, "zero");
		$display("test skew done");
		// retry limit passed, total not
		apb(1'b1, link_train_pkg::OFS_LIMIT, 32'h0f02);
		train(1'b0, 4'h0, 2'h0, 1'b0);
		wait_st(link_train_pkg::ST_BACK, "retry lim");
		chk(t0_sel, link_train_pkg::T0_200US, "200us");
		$display("test retry limit done");
		// both limits passed
		apb(1'b1, link_train_pkg::OFS_LIMIT, 32'h0);
		train(1'b0, 4'h0, 2'h0, 1'b0);
		wait_st(link_train_pkg::ST_FLOOD, "fail");
		chk({scram_en, flood_all}, 2'h3, "fail scram");
		apb(1'b0, link_train_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h30, 32'h30, "fail flags");
		warm;
		$display("test fail done");
		// ac mode, marker on all lanes
		apb(1'b1, link_train_pkg::OFS_CTRL, 32'h3);
		// receiver error while the transmitter still sends patterns
		train(1'b1, 4'h0, 2'h0, 1'b0);
		repeat (100) @(posedge sys_clk);
		pulse(1);
		wait_st(link_train_pkg::ST_RETRY, "early err");
		wait_st(link_train_pkg::ST_IDLE, "early idle");
		$display("test early error done");
		for (int k = 0; k < 10; k++)
			oper(k < 6 ? k : int'($urandom % 6));
		summarize;
	end

	// watchdog
	initial begin
		#200000;
		n_mismatch++;
		summarize;
	end
endmodule // link_final_training_and_operational_fsm_bench
`default_nettype wire
